// [rtl/loco_decoder_config_store.sv]
// decoder core: address match, lighting, momentum and configuration access
`timescale 1ns/1ps

// Functional notes
// - out of the box the decoder answers to locomotive address 3.
// - the lighting function key lights the lamp facing the direction of travel.
// - with lights on, each reversal swaps headlight and backup light.
// - the dimmer function key drives the lit headlight at reduced intensity.
// - every configuration variable is kept across a reset.
// - a configuration variable can be rewritten any number of times, last write wins.
// - each configuration variable is eight bits and holds any value 0 to 255.
// - variable 3 holds the acceleration rate, every value 0 to 255 steering it.
// - in variable 29 bit 4 enables the speed table and bit 1 selects 28 steps.
// - bit-field variables weigh bit 0 as 1 doubling up to bit 7 as 128.
module loco_decoder_config_store #(
    parameter int TICK_CYCLES = decoder_pkg::ACCEL_TICK_CYCLES,
    parameter int CV_DEPTH    = decoder_pkg::CV_DEPTH
) (
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    input  wire logic                     cmd_valid_in,
    input  wire decoder_pkg::loco_cmd_type cmd_in,
    input  wire decoder_pkg::cv_req_type  cv_req_in,
    output logic                          cv_ready_out,
    output logic                          cv_write_done_out,
    output logic                          cv_read_valid_out,
    output logic [7:0]                    cv_read_data_out,
    output logic                          address_match_out,
    output logic                          forward_out,
    output logic [4:0]                    target_speed_out,
    output logic [4:0]                    speed_out,
    output logic [decoder_pkg::FN_COUNT-1:0] functions_out,
    output logic                          headlight_out,
    output logic                          backup_light_out,
    output logic [7:0]                    acceleration_rate_out,
    output logic                          speed_table_enable_out,
    output logic                          step28_mode_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // taps from the store
    logic [7:0] store_read_data;
    logic [7:0] store_address;
    logic [7:0] store_acceleration;
    logic [7:0] store_configuration;
    logic       store_ready;

    // command state
    logic                           forward;
    logic [4:0]                     target_speed;
    logic [4:0]                     speed;
    logic [decoder_pkg::FN_COUNT-1:0] functions;
    logic                           match_pulse;

    // momentum state
    logic [TW-1:0] tick_count;
    logic [7:0]    wait_count;

    // registered configuration views
    logic [7:0] acceleration_rate;
    logic [7:0] decoder_configuration;

    // configuration_variable access decode
    wire cv_write = cv_req_in.write && store_ready;
    wire cv_read  = cv_req_in.read && store_ready && !cv_req_in.write;

    cv_store #(
        .DEPTH (CV_DEPTH)
    ) store (
        .clk_in            (clk_in),
        .rstn_in           (rstn_in),
        .write_in          (cv_write),
        .write_number_in   (cv_req_in.number),
        .write_data_in     (cv_req_in.data),
        .read_number_in    (cv_req_in.number),
        .read_data_out     (store_read_data),
        .address_out       (store_address),
        .acceleration_out  (store_acceleration),
        .configuration_out (store_configuration),
        .ready_out         (store_ready)
    );

    // configuration fields, bit n weighs two to the n
    wire step28_mode  = decoder_configuration[decoder_pkg::CFG_STEP28_BIT];
    wire speed_table  = decoder_configuration[decoder_pkg::CFG_SPEED_TABLE_BIT];

    // address decode: only the stored primary address is answered
    wire address_hit  = store_ready && (cmd_in.address == store_address[6:0])
                        && (cmd_in.address != 7'h00);
    wire cmd_accept   = cmd_valid_in && address_hit;

    // without 28-step mode the half steps are dropped
    wire [4:0] cmd_speed = step28_mode ? cmd_in.speed : {cmd_in.speed[4:1], 1'b0};

    // lighting selection follows the direction of travel
    wire lights_on    = functions[decoder_pkg::LIGHTING_FUNCTION_KEY];
    wire dim_on       = functions[decoder_pkg::DIMMER_FUNCTION_KEY];
    wire head_lit     = lights_on && forward;
    wire back_lit     = lights_on && !forward;

    // momentum stepping decode
    wire       tick       = tick_count == TW'(TICK_CYCLES - 1);
    wire       at_target  = speed == target_speed;
    wire       step_due   = wait_count >= acceleration_rate;
    wire [4:0] next_speed = (speed < target_speed) ? speed + 5'h01 : speed - 5'h01;

    // lamp drivers
    light_pwm head_lamp (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .lit_in    (head_lit),
        .dim_in    (dim_on),
        .drive_out (headlight_out)
    );

    light_pwm back_lamp (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .lit_in    (back_lit),
        .dim_in    (1'b0),
        .drive_out (backup_light_out)
    );

    // latch commands addressed to this decoder
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            forward      <= 1'b1;
            target_speed <= 5'h00;
            functions    <= '0;
            match_pulse  <= 1'b0;
        end else begin
            match_pulse <= cmd_accept;
            if (cmd_accept) begin
                forward      <= cmd_in.forward;
                target_speed <= cmd_speed;
                functions    <= cmd_in.functions;
            end
        end
    end

    // configuration views refreshed from the store every cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acceleration_rate     <= 8'h00;
            decoder_configuration <= 8'h00;
        end else begin
            acceleration_rate     <= store_acceleration;
            decoder_configuration <= store_configuration;
        end
    end

    // momentum tick divider
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_count <= '0;
        end else if (tick) begin
            tick_count <= '0;
        end else begin
            tick_count <= tick_count + TW'(1);
        end
    end

    // ramp toward the target, one step per acceleration_rate+1 ticks
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            speed      <= 5'h00;
            wait_count <= 8'h00;
        end else if (tick) begin
            if (at_target) begin
                wait_count <= 8'h00;
            end else if (step_due) begin
                wait_count <= 8'h00;
                speed      <= next_speed;
            end else begin
                wait_count <= wait_count + 8'h01;
            end
        end
    end

    // configuration_variable read answer and write acknowledge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cv_read_valid_out <= 1'b0;
            cv_read_data_out  <= 8'h00;
            cv_write_done_out <= 1'b0;
        end else begin
            cv_read_valid_out <= cv_read;
            cv_write_done_out <= cv_write;
            if (cv_read) begin
                cv_read_data_out <= store_read_data;
            end
        end
    end

    // status outputs
    assign cv_ready_out           = store_ready;
    assign address_match_out      = match_pulse;
    assign forward_out            = forward;
    assign target_speed_out       = target_speed;
    assign speed_out              = speed;
    assign functions_out          = functions;
    assign acceleration_rate_out  = acceleration_rate;
    assign speed_table_enable_out = speed_table;
    assign step28_mode_out        = step28_mode;
endmodule // loco_decoder_config_store

// [rtl/decoder_pkg.sv]
// shared constants, carrier types and factory defaults of the locomotive decoder
package decoder_pkg;

    // configuration variable numbers used as store indices
    localparam logic [7:0] CV_PRIMARY_ADDRESS       = 8'h01;
    localparam logic [7:0] CV_ACCELERATION_RATE     = 8'h03;
    localparam logic [7:0] CV_DECODER_CONFIGURATION = 8'h1d;
    localparam int         CV_DEPTH                 = 32;
    localparam int         CV_WIDTH                 = 8;

    // decoder_configuration field positions
    localparam int CFG_STEP28_BIT      = 1;
    localparam int CFG_SPEED_TABLE_BIT = 4;

    // factory defaults loaded into blank storage
    localparam logic [7:0] DEFAULT_ADDRESS       = 8'h03;
    localparam logic [7:0] DEFAULT_ACCELERATION  = 8'h00;
    localparam logic [7:0] DEFAULT_CONFIGURATION = 8'h02;
    localparam logic [7:0] STORE_VALID_MARK      = 8'h5a; // arbitrary marker value

    // function key positions
    localparam int FN_COUNT              = 13;
    localparam int LIGHTING_FUNCTION_KEY = 0;
    localparam int DIMMER_FUNCTION_KEY   = 7;

    // lighting intensity
    localparam logic [7:0] DIM_LEVEL = 8'h40;

    // momentum tick: one ramp tick per microsecond at 200 MHz
    localparam int CLK_MHZ           = 200;
    localparam int ACCEL_TICK_US     = 1;
    localparam int ACCEL_TICK_CYCLES = ACCEL_TICK_US * CLK_MHZ;

    // one speed/direction/function command from the track front end
    typedef struct packed {
        logic [6:0]          address;
        logic                forward;
        logic [4:0]          speed;
        logic [FN_COUNT-1:0] functions;
    } loco_cmd_type;

    // one configuration_variable access
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] number;
        logic [7:0] data;
    } cv_req_type;

    // factory default of each configuration_variable
    function automatic logic [7:0] default_value(input logic [7:0] number);
        logic [7:0] value;
        value = 8'h00;
        case (number)
            CV_PRIMARY_ADDRESS:       value = DEFAULT_ADDRESS;
            CV_ACCELERATION_RATE:     value = DEFAULT_ACCELERATION;
            CV_DECODER_CONFIGURATION: value = DEFAULT_CONFIGURATION;
            default:                  value = 8'h00;
        endcase
        return value;
    endfunction

endpackage

// [rtl/cv_store.sv]
// retained configuration_variable array with factory default fill
`timescale 1ns/1ps

module cv_store #(
    parameter int DEPTH = decoder_pkg::CV_DEPTH
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       write_in,
    input  wire logic [7:0] write_number_in,
    input  wire logic [7:0] write_data_in,
    input  wire logic [7:0] read_number_in,
    output logic      [7:0] read_data_out,
    output logic      [7:0] address_out,
    output logic      [7:0] acceleration_out,
    output logic      [7:0] configuration_out,
    output logic            ready_out
);
    localparam int IW = $clog2(DEPTH);

    typedef enum logic [2:0] {
        CHECK = 3'b001,
        FILL  = 3'b010,
        READY = 3'b100
    } store_state_type;

    store_state_type state;
    logic [7:0]      fill_index;
    logic [7:0]      cells [DEPTH];
    logic [7:0]      mark;

    // decode of accesses and the end of the fill
    wire write_ok  = (state == READY) && write_in && (write_number_in < DEPTH);
    wire read_ok   = read_number_in < DEPTH;
    wire fill_last = fill_index == 8'(DEPTH - 1);
    wire filling   = state == FILL;

    assign ready_out         = state == READY;
    assign read_data_out     = read_ok ? cells[read_number_in[IW-1:0]] : 8'h00;
    assign address_out       = cells[decoder_pkg::CV_PRIMARY_ADDRESS[IW-1:0]];
    assign acceleration_out  = cells[decoder_pkg::CV_ACCELERATION_RATE[IW-1:0]];
    assign configuration_out = cells[decoder_pkg::CV_DECODER_CONFIGURATION[IW-1:0]];

    // storage cells carry no reset so contents outlive a reset
    always_ff @(posedge clk_in) begin
        if (filling) begin
            cells[fill_index[IW-1:0]] <= decoder_pkg::default_value(fill_index);
        end else if (write_ok) begin
            cells[write_number_in[IW-1:0]] <= write_data_in;
        end
    end

    // marker that storage has been filled once
    always_ff @(posedge clk_in) begin
        if (filling && fill_last) begin
            mark <= decoder_pkg::STORE_VALID_MARK;
        end
    end

    // blank check after reset, then fill or go straight to ready
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state      <= CHECK;
            fill_index <= 8'h00;
        end else begin
            unique case (state)
                CHECK: begin
                    fill_index <= 8'h00;
                    if (mark == decoder_pkg::STORE_VALID_MARK) begin
                        state <= READY;
                    end else begin
                        state <= FILL;
                    end
                end
                FILL: begin
                    fill_index <= fill_index + 8'h01;
                    if (fill_last) begin
                        state <= READY;
                    end
                end
                READY: state <= READY;
            endcase
        end
    end
endmodule // cv_store

// [rtl/light_pwm.sv]
// one lighting output with full or dimmed intensity
`timescale 1ns/1ps

module light_pwm #(
    parameter logic [7:0] DIM_LEVEL = decoder_pkg::DIM_LEVEL
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic lit_in,
    input  wire logic dim_in,
    output logic      drive_out
);
    logic [7:0] phase;

    // pwm slot is on below the dim level
    wire slot_on  = phase < DIM_LEVEL;
    wire next_out = lit_in && (!dim_in || slot_on);

    // free running phase and registered drive
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase     <= 8'h00;
            drive_out <= 1'b0;
        end else begin
            phase     <= phase + 8'h01;
            drive_out <= next_out;
        end
    end
endmodule // light_pwm

// [sim/decoder_props.sv]
// property checker on the decoder core ports
`timescale 1ns/1ps
module decoder_props (
    input wire logic                     clk_in,
    input wire logic                     rstn_in,
    input wire decoder_pkg::cv_req_type  cv_req_in,
    input wire logic                     cv_ready_out,
    input wire logic                     cv_write_done_out,
    input wire logic                     cv_read_valid_out,
    input wire logic                     forward_out,
    input wire logic [12:0]              functions_out,
    input wire logic                     headlight_out,
    input wire logic                     backup_light_out,
    input wire logic [7:0]               acceleration_rate_out,
    input wire logic                     speed_table_enable_out,
    input wire logic                     step28_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // access answers and refusals
    a_write_done: assert property (cv_ready_out && cv_req_in.write |=> cv_write_done_out)
        else $error("write not acknowledged");
    a_read_valid: assert property (cv_ready_out && cv_req_in.read && !cv_req_in.write
        |=> cv_read_valid_out)
        else $error("read not answered");
    a_unready_quiet: assert property (!cv_ready_out |=> !cv_write_done_out && !cv_read_valid_out)
        else $error("access answered before store ready");
    // register views follow a write two cycles later
    a_accel_copy: assert property (cv_ready_out && cv_req_in.write && cv_req_in.number == 8'h03
        |=> ##1 acceleration_rate_out == $past(cv_req_in.data, 2))
        else $error("rate view wrong");
    a_table_bit: assert property (cv_ready_out && cv_req_in.write && cv_req_in.number == 8'h1d
        |=> ##1 speed_table_enable_out == $past(cv_req_in.data[4], 2))
        else $error("speed table flag wrong");
    a_step28_bit: assert property (cv_ready_out && cv_req_in.write && cv_req_in.number == 8'h1d
        |=> ##1 step28_mode_out == $past(cv_req_in.data[1], 2))
        else $error("step mode flag wrong");
    // lamps follow lighting key and direction
    a_head_forward: assert property (functions_out[0] && forward_out && !functions_out[7]
        |=> headlight_out && !backup_light_out)
        else $error("headlight not lit forward");
    a_backup_reverse: assert property (functions_out[0] && !forward_out
        |=> backup_light_out && !headlight_out)
        else $error("backup light not lit reverse");
    a_lights_off: assert property (!functions_out[0] |=> !headlight_out && !backup_light_out)
        else $error("lamp lit without key");
endmodule // decoder_props

// [sim/command_station.sv]
// command station model driving commands and configuration accesses
`timescale 1ns/1ps
module command_station (
    input  wire logic                 clk_in,
    input  wire logic                 cv_write_done_in,
    input  wire logic                 cv_read_valid_in,
    input  wire logic [7:0]           cv_read_data_in,
    output logic                      cmd_valid_out,
    output decoder_pkg::loco_cmd_type cmd_out,
    output decoder_pkg::cv_req_type   cv_req_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
        cv_req_out = '0;
    end
    // one access held for one edge; released number and data show the inverse value
    task automatic cv_access(input logic wr, input logic [7:0] num, input logic [7:0] dat,
                             output logic ack, output logic [7:0] rd);
        @(negedge clk_in);
        cv_req_out = '{write: wr, read: !wr, number: num, data: dat};
        @(negedge clk_in);
        // answer pulses stand only in the cycle after the taking edge
        ack = wr ? cv_write_done_in : cv_read_valid_in;
        rd = cv_read_data_in;
        cv_req_out = '{write: 1'b0, read: 1'b0, number: ~num, data: ~dat};
    endtask
    // one speed, direction and function command
    task automatic send_cmd(input logic [6:0] adr, input logic fwd, input logic [12:0] fn,
                            input logic [4:0] spd);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_out = '{address: adr, forward: fwd, speed: spd, functions: fn};
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_out = ~cmd_out;
    endtask
endmodule // command_station

// [sim/test_loco_decoder_config_store.sv]
// self-checking bench for the decoder core
`timescale 1ns/1ps
module test_loco_decoder_config_store;
    logic                      clk_in, rstn_in, cmd_valid_in, ack;
    decoder_pkg::loco_cmd_type cmd_in;
    decoder_pkg::cv_req_type   cv_req_in;
    logic                      cv_ready_out, cv_write_done_out, cv_read_valid_out;
    logic                      address_match_out, headlight_out, backup_light_out;
    logic                      speed_table_enable_out, step28_mode_out;
    logic [7:0]                cv_read_data_out, acceleration_rate_out, rd;
    logic [4:0]                speed_out, target_speed_out;
    logic [7:0]                rates [3] = '{8'hff, 8'ha5, 8'h00};
    int                        miscompares = 0;
    int                        tests_run = 0;
    int                        lit;

    loco_decoder_config_store #(.TICK_CYCLES(2), .CV_DEPTH(decoder_pkg::CV_DEPTH)) i_dut (
        .clk_in, .rstn_in, .cmd_valid_in, .cmd_in, .cv_req_in, .cv_ready_out,
        .cv_write_done_out, .cv_read_valid_out, .cv_read_data_out, .address_match_out,
        .forward_out(), .target_speed_out, .speed_out, .functions_out(), .headlight_out,
        .backup_light_out, .acceleration_rate_out, .speed_table_enable_out, .step28_mode_out);
    command_station i_station (
        .clk_in, .cv_write_done_in(cv_write_done_out), .cv_read_valid_in(cv_read_valid_out),
        .cv_read_data_in(cv_read_data_out), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in),
        .cv_req_out(cv_req_in));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 100; i++) begin
            @(negedge clk_in);
            if (cv_ready_out === 1'b1) return;
        end
        miscompares++;
        $display("CHECK FAILED at %0t: store never ready", $time);
        tally_and_finish;
    endtask
    task automatic cv_write(input logic [7:0] num, input logic [7:0] dat);
        i_station.cv_access(1'b1, num, dat, ack, rd);
        check({7'h00, ack}, 8'h01, "write done");
    endtask
    task automatic cv_read(input logic [7:0] num, input logic [7:0] exp);
        i_station.cv_access(1'b0, num, 8'h00, ack, rd);
        check({7'h00, ack}, 8'h01, "read valid");
        check(rd, exp, "read data");
    endtask

    initial begin
        rstn_in = 1'b0;
        repeat (5) @(negedge clk_in);
        rstn_in = 1'b1;
        // a write during the default fill is dropped
        i_station.cv_access(1'b1, 8'h03, 8'h99, ack, rd);
        check({7'h00, ack}, 8'h00, "early write");
        wait_ready;
        cv_read(decoder_pkg::CV_PRIMARY_ADDRESS, 8'h03);
        cv_read(decoder_pkg::CV_ACCELERATION_RATE, decoder_pkg::DEFAULT_ACCELERATION);
        cv_read(decoder_pkg::CV_DECODER_CONFIGURATION, decoder_pkg::DEFAULT_CONFIGURATION);
        // both ends of the byte range and rewrites of the rate
        foreach (rates[i]) begin
            cv_write(decoder_pkg::CV_ACCELERATION_RATE, rates[i]);
            @(negedge clk_in);
            check(acceleration_rate_out, rates[i], "rate view");
            cv_read(decoder_pkg::CV_ACCELERATION_RATE, rates[i]);
        end
        // single bit weights of the configuration byte
        for (int b = 0; b < 8; b++) begin
            cv_write(decoder_pkg::CV_DECODER_CONFIGURATION, 8'h01 << b);
            @(negedge clk_in);
            check({6'h00, speed_table_enable_out, step28_mode_out}, {6'h00, b == 4, b == 1},
                  "config flags");
            cv_read(decoder_pkg::CV_DECODER_CONFIGURATION, 8'h01 << b);
        end
        cv_write(decoder_pkg::CV_DECODER_CONFIGURATION, 8'h12);
        @(negedge clk_in);
        check({6'h00, speed_table_enable_out, step28_mode_out}, 8'h03, "table and 28");
        // lighting follows key and direction
        i_station.send_cmd(7'h03, 1'b1, 13'h0001, 5'h00);
        check({7'h00, address_match_out}, 8'h01, "address 3 match");
        @(negedge clk_in);
        check({6'h00, headlight_out, backup_light_out}, 8'h02, "forward lamps");
        i_station.send_cmd(7'h03, 1'b0, 13'h0001, 5'h00);
        @(negedge clk_in);
        check({6'h00, headlight_out, backup_light_out}, 8'h01, "reverse lamps");
        i_station.send_cmd(7'h03, 1'b1, 13'h0001, 5'h00);
        @(negedge clk_in);
        check({6'h00, headlight_out, backup_light_out}, 8'h02, "forward again");
        i_station.send_cmd(7'h04, 1'b0, 13'h0000, 5'h00);
        check({7'h00, address_match_out}, 8'h00, "other address");
        // dimmed headlight duty over one pwm period
        i_station.send_cmd(7'h03, 1'b1, 13'h0081, 5'h00);
        @(negedge clk_in);
        lit = 0;
        repeat (256) begin
            @(negedge clk_in);
            lit += int'(headlight_out);
        end
        check(8'(lit), decoder_pkg::DIM_LEVEL, "dimmed duty");
        // rate 3 with two-cycle ticks gives one speed step per eight cycles
        cv_write(decoder_pkg::CV_ACCELERATION_RATE, 8'h03);
        i_station.send_cmd(7'h03, 1'b1, 13'h0001, 5'h05);
        check({3'h0, target_speed_out}, 8'h05, "target speed");
        repeat (37) @(negedge clk_in);
        check({3'h0, speed_out}, 8'h04, "ramp midway");
        repeat (3) @(negedge clk_in);
        check({3'h0, speed_out}, 8'h05, "ramp done");
        // without 28-step mode the odd speed step is dropped
        cv_write(decoder_pkg::CV_DECODER_CONFIGURATION, 8'h00);
        i_station.send_cmd(7'h03, 1'b1, 13'h0001, 5'h05);
        check({3'h0, target_speed_out}, 8'h04, "even step target");
        // stored value survives a reset
        cv_write(decoder_pkg::CV_ACCELERATION_RATE, 8'h77);
        rstn_in = 1'b0;
        repeat (5) @(negedge clk_in);
        rstn_in = 1'b1;
        wait_ready;
        cv_read(decoder_pkg::CV_ACCELERATION_RATE, 8'h77);
        tally_and_finish;
    end
endmodule // test_loco_decoder_config_store

bind loco_decoder_config_store decoder_props i_props (
    .clk_in, .rstn_in, .cv_req_in, .cv_ready_out, .cv_write_done_out, .cv_read_valid_out,
    .forward_out, .functions_out, .headlight_out, .backup_light_out, .acceleration_rate_out,
    .speed_table_enable_out, .step28_mode_out);
